/* include/tseg_pkg.sv */
package tseg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned REG_W = 16;
    localparam int unsigned REQ_W = 8;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned NCHAN = 4;

    typedef logic [ADDR_W-1:0] tseg_addr_t;
    typedef logic [DATA_W-1:0] tseg_data_t;
    typedef logic [STRB_W-1:0] tseg_strb_t;
    typedef logic [1:0] tseg_resp_t;
    typedef logic [REG_W-1:0] tseg_reg_t;
    typedef logic [REG_W-1:0] tseg_cnt_t;
    typedef logic [REQ_W-1:0] tseg_req_t;
    typedef logic [NCHAN-1:0] tseg_chan_t;

    // Register offsets
    localparam tseg_addr_t OFF_CONFIG = 8'h00;
    localparam tseg_addr_t OFF_ENABLE = 8'h0C;
    localparam tseg_addr_t OFF_STATUS = 8'h10;
    localparam tseg_addr_t OFF_EVGEN = 8'h14;
    localparam tseg_addr_t OFF_RELOAD = 8'h2C;
    localparam tseg_addr_t OFF_CAPT0 = 8'h34;
    localparam tseg_addr_t CAPT_STEP = 8'h04;

    // Event generation bits
    localparam int unsigned EG_UPDATE = 0;
    localparam int unsigned EG_CHAN0 = 1;
    localparam int unsigned EG_COMMUT = 5;
    localparam int unsigned EG_TRIGGER = 6;
    localparam int unsigned EG_BREAK = 7;

    // Status bits
    localparam int unsigned ST_UPDATE = 0;
    localparam int unsigned ST_CHAN0 = 1;
    localparam int unsigned ST_COMMUT = 5;
    localparam int unsigned ST_TRIGGER = 6;
    localparam int unsigned ST_BREAK = 7;
    localparam int unsigned ST_REPEAT0 = 9;
    localparam int unsigned ST_RSVD_LO = 13;

    // Configuration and enable bits
    localparam int unsigned CFG_UPD_DIS = 0;
    localparam int unsigned CFG_URS = 1;
    localparam int unsigned CFG_DOWN = 2;
    localparam int unsigned CFG_CENTER = 3;
    localparam int unsigned CFG_INMODE0 = 4;
    localparam int unsigned EN_IRQ0 = 1;
    localparam int unsigned EN_DMA0 = 9;

    // Reset and fill values
    localparam tseg_reg_t RST_REG = 16'h0000;
    localparam tseg_reg_t RST_RELOAD = 16'hFFFF;
    localparam tseg_cnt_t CNT_ZERO = 16'h0000;
    localparam tseg_req_t REQ_IDLE = 8'h00;
    localparam tseg_reg_t READ_PAD = 16'h0000;
    localparam tseg_addr_t ADDR_ZERO = 8'h00;
    localparam tseg_data_t DATA_ZERO = 32'h0000_0000;
    localparam tseg_strb_t STRB_NONE = 4'h0;
    localparam tseg_resp_t RESP_OKAY = 2'h0;
    localparam tseg_resp_t RESP_SLVERR = 2'h2;
endpackage

/* rtl/tseg_axil.sv */
module tseg_axil (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Write channels
    input wire tseg_pkg::tseg_addr_t awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire tseg_pkg::tseg_data_t wdata,
    input wire tseg_pkg::tseg_strb_t wstrb,
    input wire logic wvalid,
    output logic wready,
    output tseg_pkg::tseg_resp_t bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire tseg_pkg::tseg_addr_t araddr,
    input wire logic arvalid,
    output logic arready,
    output tseg_pkg::tseg_data_t rdata,
    output tseg_pkg::tseg_resp_t rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic wr_en,
    output tseg_pkg::tseg_addr_t wr_addr,
    output tseg_pkg::tseg_data_t wr_data,
    output tseg_pkg::tseg_strb_t wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    input wire tseg_pkg::tseg_data_t rd_data,
    input wire logic rd_ok
);
    import tseg_pkg::*;

    logic aw_held;
    logic w_held;

    // Address and data may arrive in either order
    assign wr_en = aw_held && w_held && !bvalid;
    assign rd_en = arvalid && arready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= ADDR_ZERO;
            wr_data <= DATA_ZERO;
            wr_strb <= STRB_NONE;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_en) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            // Readies come back only after the response, one write at a time
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= DATA_ZERO;
            rresp <= RESP_OKAY;
        end else if (rd_en) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

/* rtl/tseg_chan.sv */
module tseg_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic input_mode,
    input wire logic irq_en,
    input wire logic dma_en,
    input wire logic flag_clr,
    input wire logic repeat_clr,
    // Events
    input wire logic hw_event,
    input wire logic sw_request,
    input wire tseg_pkg::tseg_cnt_t count,
    // State and requests
    output logic flag,
    output logic repeat_flag,
    output tseg_pkg::tseg_cnt_t capture_value,
    output logic irq_req,
    output logic dma_req
);
    import tseg_pkg::*;

    wire event_set = sw_request || hw_event;
    wire capture = input_mode && event_set;
    wire repeat_set = capture && flag;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'b0;
            repeat_flag <= 1'b0;
            capture_value <= CNT_ZERO;
            irq_req <= 1'b0;
            dma_req <= 1'b0;
        end else begin
            flag <= event_set || (flag && !flag_clr);
            repeat_flag <= repeat_set || (repeat_flag && !repeat_clr);
            if (capture) begin
                capture_value <= count;
            end
            irq_req <= event_set && irq_en;
            dma_req <= event_set && dma_en;
        end
    end

    a_repeat_set: assert property (
        @(posedge clk) disable iff (!arst_n)
        capture && flag |=> repeat_flag
    ) else $error("Repeat flag not set on second capture");

    a_repeat_output: assert property (
        @(posedge clk) disable iff (!arst_n)
        !input_mode && !repeat_flag |=> !repeat_flag
    ) else $error("Repeat flag set in output mode");

    a_out_request: assert property (
        @(posedge clk) disable iff (!arst_n)
        sw_request && !input_mode |=> flag && irq_req == $past(irq_en)
            && dma_req == $past(dma_en)
    ) else $error("Output mode request missing flag or request");

    a_capture_value: assert property (
        @(posedge clk) disable iff (!arst_n)
        sw_request && input_mode |=> flag && capture_value == $past(count)
    ) else $error("Forced capture did not store counter");
endmodule

/* rtl/tseg_top.sv */
// Contract
// - Capture with the flag set sets the repeat flag; writing zero clears it.
// - The repeat flag is only set while the channel is in input capture mode.
// - Repeat flags one to four are status bits 9 to 12; bits 15:13 are zero.
// - Bit 0 written one reloads the counter as an update; zero is ignored.
// - The update request clears itself in hardware and so acts once.
// - Any update clears the prescaler counter but keeps its division factor.
// - A software update loads the reload value counting down when not center aligned, else zero.
// - A request in output mode sets the channel flag and enabled requests.
// - A request in input mode captures the counter and sets flag and requests.
// - A forced capture with the flag already set also sets the repeat flag.
// - Channel two to four requests sit at bits 2 to 4 and act as channel one.
// - Channel, commutation, trigger and break requests clear themselves.
// - A one in bit 5 makes a commutation event for complementary channels.
// - Writing one to bit 6 makes a trigger event as a trigger input would.
// - Writing one to bit 7 makes a break event; bits 15:8 are reserved.
// - A software update sets the update flag if select and disable are zero.
module tseg_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Write address channel
    input wire tseg_pkg::tseg_addr_t AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // Write data channel
    input wire tseg_pkg::tseg_data_t WDATA,
    input wire tseg_pkg::tseg_strb_t WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // Write response channel
    output tseg_pkg::tseg_resp_t BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // Read address channel
    input wire tseg_pkg::tseg_addr_t ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // Read data channel
    output tseg_pkg::tseg_data_t RDATA,
    output tseg_pkg::tseg_resp_t RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Counter core
    input wire tseg_pkg::tseg_cnt_t COUNT,
    input wire logic HW_UPDATE,
    output logic COUNTER_LOAD,
    output tseg_pkg::tseg_cnt_t COUNTER_LOAD_VALUE,
    output logic PRESCALER_CLEAR,
    // Channel logic
    input wire tseg_pkg::tseg_chan_t CHAN_HW_EVENT,
    output tseg_pkg::tseg_chan_t CHAN_SW_EVENT,
    output tseg_pkg::tseg_chan_t CHAN_IRQ_REQ,
    output tseg_pkg::tseg_chan_t CHAN_DMA_REQ,
    // Control events
    output logic COMMUTATION_EVENT,
    output logic TRIGGER_EVENT,
    output logic BREAK_EVENT
);
    import tseg_pkg::*;

    function automatic tseg_reg_t lane_mask(input tseg_strb_t strb);
        lane_mask = {{LANE_W{strb[1]}}, {LANE_W{strb[0]}}};
    endfunction

    function automatic tseg_reg_t merge(
        input tseg_reg_t old,
        input tseg_reg_t val,
        input tseg_reg_t mask
    );
        merge = (old & ~mask) | (val & mask);
    endfunction

    function automatic logic capt_hit(
        input tseg_addr_t addr,
        input int unsigned idx
    );
        capt_hit = addr == tseg_addr_t'(OFF_CAPT0 + idx * CAPT_STEP);
    endfunction

    // Bus side
    logic wr_en;
    tseg_addr_t wr_addr;
    tseg_data_t wr_data;
    tseg_strb_t wr_strb;
    logic wr_ok;
    logic rd_en;
    tseg_data_t rd_data;
    logic rd_ok;

    // Software state
    tseg_reg_t cfg;
    tseg_reg_t enable;
    tseg_reg_t reload;
    tseg_req_t req;
    tseg_cnt_t load_value;
    logic presc_clr;
    logic upd_flag;
    logic com_flag;
    logic trg_flag;
    logic brk_flag;

    // Channel state
    tseg_chan_t chan_flag;
    tseg_chan_t rep_flag;
    tseg_chan_t irq_req;
    tseg_chan_t dma_req;
    tseg_cnt_t capt_val [NCHAN];
    tseg_chan_t wr_capt_hit;
    tseg_chan_t rd_capt_hit;
    tseg_reg_t capt_word;

    tseg_axil u_axil (
        .clk(CLK),
        .arst_n(ARST_N),
        .awaddr(AWADDR),
        .awvalid(AWVALID),
        .awready(AWREADY),
        .wdata(WDATA),
        .wstrb(WSTRB),
        .wvalid(WVALID),
        .wready(WREADY),
        .bresp(BRESP),
        .bvalid(BVALID),
        .bready(BREADY),
        .araddr(ARADDR),
        .arvalid(ARVALID),
        .arready(ARREADY),
        .rdata(RDATA),
        .rresp(RRESP),
        .rvalid(RVALID),
        .rready(RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Write decode
    wire tseg_reg_t wr_mask = lane_mask(wr_strb);
    wire tseg_reg_t wr_val = wr_data[REG_W-1:0];
    wire tseg_reg_t wr_set = wr_val & wr_mask;
    wire wr_cfg = wr_en && wr_addr == OFF_CONFIG;
    wire wr_ena = wr_en && wr_addr == OFF_ENABLE;
    wire wr_sts = wr_en && wr_addr == OFF_STATUS;
    wire wr_evg = wr_en && wr_addr == OFF_EVGEN;
    wire wr_rld = wr_en && wr_addr == OFF_RELOAD;
    // Capture registers are read only; writes there are accepted and dropped
    assign wr_ok = wr_addr == OFF_CONFIG || wr_addr == OFF_ENABLE
        || wr_addr == OFF_STATUS || wr_addr == OFF_EVGEN
        || wr_addr == OFF_RELOAD || |wr_capt_hit;

    // Configuration fields
    wire cfg_udis = cfg[CFG_UPD_DIS];
    wire cfg_urs = cfg[CFG_URS];
    wire cfg_down = cfg[CFG_DOWN];
    wire cfg_center = cfg[CFG_CENTER];
    wire tseg_chan_t cfg_inmode = cfg[CFG_INMODE0 +: NCHAN];
    wire tseg_chan_t en_irq = enable[EN_IRQ0 +: NCHAN];
    wire tseg_chan_t en_dma = enable[EN_DMA0 +: NCHAN];

    wire wr_upd = wr_evg && wr_set[EG_UPDATE];
    wire wr_com = wr_evg && wr_set[EG_COMMUT];
    wire wr_trg = wr_evg && wr_set[EG_TRIGGER];
    wire wr_brk = wr_evg && wr_set[EG_BREAK];
    wire tseg_chan_t wr_chan = wr_set[EG_CHAN0 +: NCHAN];
    wire tseg_req_t next_req = wr_evg ? wr_set[REQ_W-1:0] : REQ_IDLE;
    wire tseg_cnt_t next_load_value = (cfg_down && !cfg_center)
        ? reload : CNT_ZERO;
    wire next_presc_clr = next_req[EG_UPDATE] || HW_UPDATE;
    // Status bits are cleared by writing zero on an enabled lane
    wire tseg_reg_t status_clr = wr_sts ? (~wr_val & wr_mask) : RST_REG;
    wire upd_set = ((req[EG_UPDATE] && !cfg_urs) || HW_UPDATE) && !cfg_udis;

    wire tseg_reg_t status_word = (tseg_reg_t'(rep_flag) << ST_REPEAT0)
        | (tseg_reg_t'(brk_flag) << ST_BREAK)
        | (tseg_reg_t'(trg_flag) << ST_TRIGGER)
        | (tseg_reg_t'(com_flag) << ST_COMMUT)
        | (tseg_reg_t'(chan_flag) << ST_CHAN0)
        | (tseg_reg_t'(upd_flag) << ST_UPDATE);

    // Read decode
    // event register reads zero
    wire tseg_reg_t rd_word = ARADDR == OFF_CONFIG ? cfg
        : ARADDR == OFF_ENABLE ? enable
        : ARADDR == OFF_STATUS ? status_word
        : ARADDR == OFF_RELOAD ? reload
        : |rd_capt_hit ? capt_word
        : RST_REG;
    assign rd_data = {READ_PAD, rd_word};
    assign rd_ok = ARADDR == OFF_CONFIG || ARADDR == OFF_ENABLE
        || ARADDR == OFF_STATUS || ARADDR == OFF_EVGEN
        || ARADDR == OFF_RELOAD || |rd_capt_hit;

    always_comb begin
        capt_word = RST_REG;
        for (int i = 0; i < NCHAN; i++) begin
            if (rd_capt_hit[i]) begin
                capt_word = capt_val[i];
            end
        end
    end

    for (genvar i = 0; i < NCHAN; i++) begin : g_chan
        assign wr_capt_hit[i] = capt_hit(wr_addr, i);
        assign rd_capt_hit[i] = capt_hit(ARADDR, i);
        // Reading a capture value also clears its flag
        tseg_chan u_chan (
            .clk(CLK),
            .arst_n(ARST_N),
            .input_mode(cfg_inmode[i]),
            .irq_en(en_irq[i]),
            .dma_en(en_dma[i]),
            .flag_clr(status_clr[ST_CHAN0 + i] || (rd_en && rd_capt_hit[i])),
            .repeat_clr(status_clr[ST_REPEAT0 + i]),
            .hw_event(CHAN_HW_EVENT[i]),
            .sw_request(req[EG_CHAN0 + i]),
            .count(COUNT),
            .flag(chan_flag[i]),
            .repeat_flag(rep_flag[i]),
            .capture_value(capt_val[i]),
            .irq_req(irq_req[i]),
            .dma_req(dma_req[i])
        );
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg <= RST_REG;
            enable <= RST_REG;
            reload <= RST_RELOAD;
        end else begin
            if (wr_cfg) begin
                cfg <= merge(cfg, wr_val, wr_mask);
            end
            if (wr_ena) begin
                enable <= merge(enable, wr_val, wr_mask);
            end
            if (wr_rld) begin
                reload <= merge(reload, wr_val, wr_mask);
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req <= REQ_IDLE;
            load_value <= CNT_ZERO;
            presc_clr <= 1'b0;
        end else begin
            req <= next_req;
            presc_clr <= next_presc_clr;
            if (wr_upd) begin
                load_value <= next_load_value;
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            upd_flag <= 1'b0;
            com_flag <= 1'b0;
            trg_flag <= 1'b0;
            brk_flag <= 1'b0;
        end else begin
            upd_flag <= upd_set || (upd_flag && !status_clr[ST_UPDATE]);
            com_flag <= req[EG_COMMUT] || (com_flag && !status_clr[ST_COMMUT]);
            trg_flag <= req[EG_TRIGGER]
                || (trg_flag && !status_clr[ST_TRIGGER]);
            brk_flag <= req[EG_BREAK] || (brk_flag && !status_clr[ST_BREAK]);
        end
    end

    // Outputs, all from flip-flops
    assign COUNTER_LOAD = req[EG_UPDATE];
    assign COUNTER_LOAD_VALUE = load_value;
    assign PRESCALER_CLEAR = presc_clr;
    assign CHAN_SW_EVENT = req[EG_CHAN0 +: NCHAN];
    assign CHAN_IRQ_REQ = irq_req;
    assign CHAN_DMA_REQ = dma_req;
    assign COMMUTATION_EVENT = req[EG_COMMUT];
    assign TRIGGER_EVENT = req[EG_TRIGGER];
    assign BREAK_EVENT = req[EG_BREAK];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_load_shot;
        COUNTER_LOAD ##1 !COUNTER_LOAD;
    endsequence

    sequence s_load_zero;
        COUNTER_LOAD && COUNTER_LOAD_VALUE == CNT_ZERO;
    endsequence

    a_update_load: assert property (
        wr_upd |=> COUNTER_LOAD && PRESCALER_CLEAR
    ) else $error("Update request did not reload counter");

    a_update_shot: assert property (
        wr_upd |=> s_load_shot
    ) else $error("Update request not single shot");

    a_presc_follow: assert property (
        HW_UPDATE |=> PRESCALER_CLEAR
    ) else $error("Prescaler not cleared on hardware update");

    a_load_down: assert property (
        wr_upd && cfg_down && !cfg_center
            |=> COUNTER_LOAD_VALUE == $past(reload)
    ) else $error("Down count did not load reload value");

    a_load_up: assert property (
        wr_upd && (!cfg_down || cfg_center) |=> s_load_zero
    ) else $error("Up or center count did not clear counter");

    a_chan_flags: assert property (
        wr_evg |-> ##2 (chan_flag & $past(wr_chan, 2)) == $past(wr_chan, 2)
    ) else $error("Channel request did not set its flag");

    a_req_clear: assert property (
        req != REQ_IDLE |=> req == REQ_IDLE
    ) else $error("Event request did not self clear");

    a_event_bits: assert property (
        wr_evg |=> TRIGGER_EVENT == $past(wr_trg)
            && BREAK_EVENT == $past(wr_brk)
            && COMMUTATION_EVENT == $past(wr_com)
    ) else $error("Control event pulse does not match write");

    a_update_flag: assert property (
        wr_upd && !cfg_urs && !cfg_udis |-> ##2 upd_flag
    ) else $error("Update flag not set by software update");

    a_status_map: assert property (
        rd_en && ARADDR == OFF_STATUS
            |=> RDATA[ST_REPEAT0 +: NCHAN] == $past(rep_flag)
            && RDATA[REG_W-1:ST_RSVD_LO] == '0
    ) else $error("Status layout wrong");

    a_evgen_zero: assert property (
        rd_en && ARADDR == OFF_EVGEN
            |=> RDATA == DATA_ZERO && RRESP == RESP_OKAY
    ) else $error("Event register did not read zero");
endmodule

/* tb/test_timer_software_event_generation.sv */
module test_timer_software_event_generation;
    timeunit 1ns;
    timeprecision 1ps;
    import tseg_pkg::*;
    logic CLK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, HW_UPDATE;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, COUNTER_LOAD;
    logic PRESCALER_CLEAR, COMMUTATION_EVENT, TRIGGER_EVENT, BREAK_EVENT;
    tseg_addr_t AWADDR, ARADDR;
    tseg_data_t WDATA, RDATA, d;
    tseg_strb_t WSTRB;
    tseg_resp_t BRESP, RRESP, r;
    tseg_cnt_t COUNT, COUNTER_LOAD_VALUE, lv;
    tseg_chan_t CHAN_HW_EVENT, CHAN_SW_EVENT, CHAN_IRQ_REQ, CHAN_DMA_REQ;
    tseg_reg_t cfg = 16'h0000;
    tseg_cnt_t rl = 16'hFFFF;
    int pc[11];
    int fail_count = 0;
    int comparisons = 0;

    tseg_top tseg_top_inst (.CLK(CLK), .ARST_N(ARST_N),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .COUNT(COUNT), .HW_UPDATE(HW_UPDATE), .COUNTER_LOAD(COUNTER_LOAD),
        .COUNTER_LOAD_VALUE(COUNTER_LOAD_VALUE),
        .PRESCALER_CLEAR(PRESCALER_CLEAR), .CHAN_HW_EVENT(CHAN_HW_EVENT),
        .CHAN_SW_EVENT(CHAN_SW_EVENT), .CHAN_IRQ_REQ(CHAN_IRQ_REQ),
        .CHAN_DMA_REQ(CHAN_DMA_REQ), .COMMUTATION_EVENT(COMMUTATION_EVENT),
        .TRIGGER_EVENT(TRIGGER_EVENT), .BREAK_EVENT(BREAK_EVENT));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Pulse counters; one count per cycle a pulse stands
    always @(posedge CLK) begin
        if (COUNTER_LOAD === 1'b1) begin
            pc[0]++;
            lv = COUNTER_LOAD_VALUE;
        end
        for (int i = 0; i < 4; i++) begin
            pc[1+i] += int'(CHAN_SW_EVENT[i] === 1'b1);
            pc[9] += int'(CHAN_IRQ_REQ[i] === 1'b1);
            pc[10] += int'(CHAN_DMA_REQ[i] === 1'b1);
        end
        pc[5] += int'(COMMUTATION_EVENT === 1'b1);
        pc[6] += int'(TRIGGER_EVENT === 1'b1);
        pc[7] += int'(BREAK_EVENT === 1'b1);
        pc[8] += int'(PRESCALER_CLEAR === 1'b1);
    end

    function automatic tseg_cnt_t exp_load(input tseg_reg_t c);
        return (c[CFG_DOWN] && !c[CFG_CENTER]) ? rl : CNT_ZERO;
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input tseg_addr_t a, input tseg_data_t v);
        logic aw;
        logic w;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= v;
        WSTRB <= 4'h3;
        {AWVALID, WVALID, BREADY} <= 3'h7;
        aw = 1'b1;
        w = 1'b1;
        do begin
            @(posedge CLK);
            if (aw && AWREADY === 1'b1) begin
                aw = 1'b0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY === 1'b1) begin
                w = 1'b0;
                WVALID <= 1'b0;
            end
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        r = BRESP;
    endtask

    task automatic rd(input tseg_addr_t a);
        logic ar;
        @(posedge CLK);
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'h3;
        ar = 1'b1;
        do begin
            @(posedge CLK);
            if (ar && ARREADY === 1'b1) begin
                ar = 1'b0;
                ARVALID <= 1'b0;
            end
        end while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        d = RDATA;
        r = RRESP;
    endtask

    task automatic pulse_test(input tseg_reg_t v);
        pc = '{default: 0};
        wr(OFF_EVGEN, 32'(v));
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        for (int b = 0; b < 8; b++) begin
            chk(32'(pc[b]), 32'(v[b]));
        end
        chk(32'(pc[8]), 32'(v[0]));
        if (v[0]) chk(32'(lv), 32'(exp_load(cfg)));
        rd(OFF_EVGEN);
        chk(d, DATA_ZERO);
        chk(32'(r), 32'(RESP_OKAY));
    endtask

    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        wrap_up();
    end

    initial begin
        ARST_N = 1'b0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, HW_UPDATE} = '0;
        {AWADDR, ARADDR, WDATA, WSTRB, COUNT, CHAN_HW_EVENT} = '0;
        repeat (6) @(posedge CLK);
        ARST_N <= 1'b1;
        void'($urandom(32'hFB85));
        rd(OFF_STATUS);
        chk(d, DATA_ZERO);
        wr(8'h08, 32'h1);
        chk(32'(r), 32'(RESP_SLVERR));
        for (int i = 0; i < 12; i++) begin
            pulse_test(i < 8 ? 16'(1 << i)
                : (i == 8 ? 16'hFF00 : 16'($urandom)));
        end
        rd(OFF_STATUS);
        chk(d & 32'h1E00, DATA_ZERO);
        chk(d & 32'h001F, 32'h001F);
        $display("done: request bits");
        rl = 16'($urandom);
        cfg = 16'h0006;
        wr(OFF_RELOAD, 32'(rl));
        wr(OFF_CONFIG, 32'(cfg));
        wr(OFF_STATUS, DATA_ZERO);
        pulse_test(16'h0001);
        rd(OFF_STATUS);
        chk(d & 32'h1, DATA_ZERO);
        pc = '{default: 0};
        @(posedge CLK);
        HW_UPDATE <= 1'b1;
        @(posedge CLK);
        HW_UPDATE <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(32'(pc[8]), 32'h1);
        // Disabled, counting down, center aligned: loads zero, no flag
        cfg = 16'h000D;
        wr(OFF_CONFIG, 32'(cfg));
        wr(OFF_STATUS, DATA_ZERO);
        pulse_test(16'h0001);
        rd(OFF_STATUS);
        chk(d & 32'h1, DATA_ZERO);
        $display("done: update");
        cfg = 16'h00F0;
        wr(OFF_CONFIG, 32'(cfg));
        for (int ch = 0; ch < 4; ch++) begin
            COUNT <= 16'($urandom);
            wr(OFF_ENABLE, 32'(32'h202 << ch));
            wr(OFF_STATUS, DATA_ZERO);
            pulse_test(16'(2 << ch));
            chk(32'(pc[9] + pc[10]), 32'h2);
            pulse_test(16'(2 << ch));
            rd(OFF_STATUS);
            chk(d & 32'hFE00, 32'(32'h200 << ch));
            rd(tseg_addr_t'(OFF_CAPT0 + 8'(4 * ch)));
            chk(d, 32'(COUNT));
            wr(OFF_STATUS, DATA_ZERO);
            rd(OFF_STATUS);
            chk(d & 32'hFE00, DATA_ZERO);
        end
        $display("done: software capture");
        repeat (2) begin
            @(posedge CLK);
            CHAN_HW_EVENT <= 4'h1;
            @(posedge CLK);
            CHAN_HW_EVENT <= 4'h0;
        end
        rd(OFF_STATUS);
        chk(d & 32'h0200, 32'h0200);
        $display("done: hardware capture");
        wrap_up();
    end
endmodule
